// [src/sac_control.sv]
/*
 * Control logic around an eight-channel successive-approximation
 * converter: registers, channel select, conversion sequencing, result
 * justification, auto-scan, completion flag and interrupt request.
 * Assumes the analog core presents a settled result on sample_data at the
 * end of the sixteenth conversion clock period and that stop_mode is high
 * while the processor is stopped.
 */
`timescale 1ns/1ns
module sac_control (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    input  wire logic       osc_tick,
    input  wire logic       stop_mode,
    input  wire logic [9:0] sample_data,
    output logic      [4:0] mux_sel,
    output logic            conv_active,
    output logic            power_off,
    output logic            irq
);

    typedef struct packed {
        sac_pkg::sac_state_e st;
        logic                resume;
        logic [4:0]          ch;
        logic                irq_enable_bit;
        logic                continuous_bit;
        logic                done;
        logic                irq;
        logic [2:0]          div;
        logic                src;
        logic [1:0]          mode;
        logic                scan_en;
        logic [1:0]          auto;
        logic [1:0]          scnt;
        logic [3:0]          tcnt;
        logic                lock;
        logic [7:0]          hi;
        logic [3:0][7:0]     lo;
        logic [7:0]          rdata;
    } sac_ctl_s;

    sac_ctl_s q;
    sac_ctl_s d;
    logic     tick;
    logic     wr_sc;
    logic     wr_ck;
    logic     wr_as;
    logic     rd_hi;
    logic     rd_lo0;
    logic     rd_lo_any;
    logic     conv_end;
    logic     cyc_end;
    logic     start_ok;

    // ------------------------------------------------------------
    // Conversion clock
    // ------------------------------------------------------------
    sac_prescaler u_pre (
        .mclk     (mclk),
        .rstn     (rstn),
        .src_bus  (q.src),
        .prescale (q.div),
        .osc_tick (osc_tick),
        .adc_tick (tick)
    );

    // ------------------------------------------------------------
    // Decode and events
    // ------------------------------------------------------------
    assign wr_sc     = wr_en && addr == sac_pkg::OFF_STATUS_CONTROL;
    assign wr_ck     = wr_en && addr == sac_pkg::OFF_CLOCK_CONTROL;
    assign wr_as     = wr_en && addr == sac_pkg::OFF_SCAN_CONTROL;
    assign rd_hi     = rd_en && addr == sac_pkg::OFF_RESULT_HIGH_0;
    assign rd_lo0    = rd_en && addr == sac_pkg::OFF_RESULT_LOW_0;
    assign rd_lo_any = rd_en && addr >= sac_pkg::OFF_RESULT_LOW_0
                             && addr <= sac_pkg::OFF_SCAN_RESULT_3;
    assign conv_end  = q.st == sac_pkg::ST_CONV && tick
                       && q.tcnt == sac_pkg::CONV_LAST_TICK;
    assign cyc_end   = conv_end && (!q.scan_en || q.scnt == q.auto);
    assign start_ok  = q.scan_en || wdata[4:0] != sac_pkg::CH_POWER_OFF;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d       = q;
        d.rdata = 8'h00;

        // Register writes
        if (wr_sc)
        begin
            d.irq_enable_bit = wdata[sac_pkg::BIT_IRQ_EN];
            d.continuous_bit = wdata[sac_pkg::BIT_CONT];
            d.ch   = wdata[4:0];
        end
        if (wr_ck)
        begin
            d.div  = wdata[sac_pkg::BIT_PRE_LSB +: 3];
            d.src  = wdata[sac_pkg::BIT_SRC];
            d.mode = wdata[sac_pkg::BIT_JUST_LSB +: 2];
        end
        if (wr_as)
        begin
            d.scan_en = wdata[sac_pkg::BIT_SCAN_EN];
            d.auto    = wdata[1:0];
        end

        // Sequencer
        unique case (q.st)
            sac_pkg::ST_IDLE:
            begin
                d.tcnt = 4'h0;
            end
            sac_pkg::ST_ALIGN:
            begin
                if (tick)
                begin
                    d.st   = sac_pkg::ST_CONV;
                    d.tcnt = 4'h0;
                end
            end
            sac_pkg::ST_CONV:
            begin
                if (tick)
                    d.tcnt = q.tcnt + 4'h1;
                if (conv_end)
                begin
                    d.tcnt = 4'h0;
                    if (q.scan_en && q.scnt != q.auto)
                        d.scnt = q.scnt + 2'h1;
                    else if (!q.scan_en && q.continuous_bit)
                        d.st = sac_pkg::ST_CONV;
                    else
                        d.st = sac_pkg::ST_IDLE;
                end
            end
        endcase

        // Control write restarts the sequence, or idles it on the power-off channel without scan
        if (wr_sc)
        begin
            d.scnt = 2'h0;
            d.tcnt = 4'h0;
            d.st   = start_ok ? sac_pkg::ST_ALIGN : sac_pkg::ST_IDLE;
        end

        // Stop aborts and remembers to resume
        if (stop_mode)
        begin
            if (d.st != sac_pkg::ST_IDLE)
                d.resume = 1'b1;
            d.st   = sac_pkg::ST_IDLE;
            d.tcnt = 4'h0;
        end
        else if (q.resume)
        begin
            d.resume = 1'b0;
            if (d.st == sac_pkg::ST_IDLE)
                d.st = sac_pkg::ST_ALIGN;
        end

        // Interlock of the result pair
        if (rd_hi && q.mode != sac_pkg::JUST_TRUNC)
            d.lock = 1'b1;
        if (rd_lo0 || wr_sc || wr_ck)
            d.lock = 1'b0;

        // Result store
        if (conv_end)
        begin
            if (q.scan_en)
                d.lo[q.scnt] = sample_data[9:2];
            else if (!q.lock || q.mode == sac_pkg::JUST_TRUNC)
            begin
                unique case (q.mode)
                    sac_pkg::JUST_TRUNC:
                    begin
                        d.hi    = 8'h00;
                        d.lo[0] = sample_data[9:2];
                    end
                    sac_pkg::JUST_RIGHT:
                    begin
                        d.hi    = {6'h00, sample_data[9:8]};
                        d.lo[0] = sample_data[7:0];
                    end
                    sac_pkg::JUST_LEFT:
                    begin
                        d.hi    = sample_data[9:2];
                        d.lo[0] = {sample_data[1:0], 6'h00};
                    end
                    sac_pkg::JUST_SIGNED:
                    begin
                        d.hi    = {~sample_data[9], sample_data[8:2]};
                        d.lo[0] = {sample_data[1:0], 6'h00};
                    end
                endcase
            end
        end

        // Completion flag, set wins over clear
        d.done = (conv_end && !q.irq_enable_bit)
                 || (q.done && !(wr_sc || wr_ck || rd_lo_any));

        // Interrupt level, set wins over clear
        d.irq = d.irq_enable_bit && ((cyc_end && q.irq_enable_bit)
                 || (q.irq && !(rd_hi || rd_lo0 || wr_sc)));

        // Read data
        if (rd_en)
        begin
            unique case (addr)
                sac_pkg::OFF_STATUS_CONTROL:
                    d.rdata = {q.done && !q.irq_enable_bit, q.irq_enable_bit, q.continuous_bit, q.ch};
                sac_pkg::OFF_CLOCK_CONTROL:
                    d.rdata = {q.div, q.src, q.mode, 2'h0};
                sac_pkg::OFF_RESULT_HIGH_0:
                    d.rdata = q.hi;
                sac_pkg::OFF_RESULT_LOW_0:
                    d.rdata = q.lo[0];
                sac_pkg::OFF_SCAN_RESULT_1:
                    d.rdata = q.lo[1];
                sac_pkg::OFF_SCAN_RESULT_2:
                    d.rdata = q.lo[2];
                sac_pkg::OFF_SCAN_RESULT_3:
                    d.rdata = q.lo[3];
                sac_pkg::OFF_SCAN_CONTROL:
                    d.rdata = {5'h00, q.scan_en, q.auto};
                default:
                    d.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            q         <= '0;
            q.st      <= sac_pkg::ST_IDLE;
            q.ch      <= sac_pkg::RST_CHANNEL;
            q.div     <= sac_pkg::RST_PRESCALE;
            q.src     <= sac_pkg::RST_SOURCE;
            q.mode    <= sac_pkg::RST_JUSTIFY;
            q.auto    <= sac_pkg::RST_AUTO;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata       = q.rdata;
    assign mux_sel     = q.scan_en ? {3'h0, q.scnt} : q.ch;
    assign power_off   = !q.scan_en && q.ch == sac_pkg::CH_POWER_OFF;
    assign conv_active = q.st != sac_pkg::ST_IDLE;
    assign irq         = q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    logic [4:0] chk_ticks_q;

    // Ticks counted since the current conversion began, cleared at each conversion end
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            chk_ticks_q <= 5'h00;
        else if (q.st != sac_pkg::ST_CONV || conv_end)
            chk_ticks_q <= 5'h00;
        else if (tick)
            chk_ticks_q <= chk_ticks_q + 5'h01;
    end

    sequence s_last_tick;
        q.st == sac_pkg::ST_CONV && tick && q.tcnt == sac_pkg::CONV_LAST_TICK;
    endsequence

    sequence s_quiet_bus;
        !wr_en && !rd_en && !stop_mode;
    endsequence

    chk_irq_gated: assert property (q.irq |-> q.irq_enable_bit)
        else $error("irq high while disabled");
    chk_irq_hold: assert property (q.irq && !rd_hi && !rd_lo0 && !wr_en |=> irq)
        else $error("irq dropped without a clear");
    chk_done_hidden: assert property (rd_en && addr == sac_pkg::OFF_STATUS_CONTROL
        && q.irq_enable_bit |=> !rdata[sac_pkg::BIT_DONE])
        else $error("done flag visible with irq enabled");
    chk_done_clear: assert property ((wr_sc || wr_ck || rd_lo_any) && !conv_end
        |=> !q.done)
        else $error("done flag not cleared");
    chk_done_set: assert property (s_last_tick and !q.irq_enable_bit |=> q.done)
        else $error("done flag not set");
    chk_irq_drop: assert property ((rd_hi || wr_sc) && !cyc_end |=> !irq)
        else $error("irq not dropped");
    chk_irq_raise: assert property (s_last_tick and (q.irq_enable_bit && !q.scan_en && !wr_en)
        |=> irq)
        else $error("irq missing after conversion");
    chk_write_start: assert property (wr_sc && start_ok && !stop_mode
        |=> q.st == sac_pkg::ST_ALIGN)
        else $error("write did not start conversion");
    chk_stop_abort: assert property (stop_mode |=> q.st == sac_pkg::ST_IDLE)
        else $error("conversion survived stop");
    chk_single_end: assert property (s_last_tick and (!q.continuous_bit && !q.scan_en) and s_quiet_bus
        |=> q.st == sac_pkg::ST_IDLE)
        else $error("single conversion repeated");
    chk_scan_reset: assert property (wr_sc && !stop_mode |=> q.scnt == 2'h0)
        else $error("scan counter not reset");
    chk_conv_len: assert property (q.st == sac_pkg::ST_CONV && tick
        |-> conv_end == (chk_ticks_q == {1'b0, sac_pkg::CONV_LAST_TICK}))
        else $error("conversion length not sixteen ticks");

endmodule : sac_control

// [src/sac_pkg.sv]
/*
 * Constants, register map and state codes of the converter control block.
 * Assumes an 8-bit register port and a 100 MHz mclk.
 */
package sac_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS_CONTROL = 8'h57;
    localparam logic [7:0] OFF_CLOCK_CONTROL  = 8'h58;
    localparam logic [7:0] OFF_RESULT_HIGH_0  = 8'h59;
    localparam logic [7:0] OFF_RESULT_LOW_0   = 8'h5a;
    localparam logic [7:0] OFF_SCAN_RESULT_1  = 8'h5b;
    localparam logic [7:0] OFF_SCAN_RESULT_2  = 8'h5c;
    localparam logic [7:0] OFF_SCAN_RESULT_3  = 8'h5d;
    localparam logic [7:0] OFF_SCAN_CONTROL   = 8'h5e;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_DONE      = 7;
    localparam int BIT_IRQ_EN    = 6;
    localparam int BIT_CONT      = 5;
    localparam int BIT_PRE_LSB   = 5;
    localparam int BIT_SRC       = 4;
    localparam int BIT_JUST_LSB  = 2;
    localparam int BIT_SCAN_EN   = 2;

    // ------------------------------------------------------------
    // Values after reset and codes
    // ------------------------------------------------------------
    localparam logic [4:0] RST_CHANNEL   = 5'h1f;
    localparam logic [2:0] RST_PRESCALE  = 3'h0;
    localparam logic       RST_SOURCE    = 1'h0;
    localparam logic [1:0] RST_JUSTIFY   = 2'h1;
    localparam logic [1:0] RST_AUTO      = 2'h0;
    localparam logic [4:0] CH_REF_HIGH   = 5'h1d;
    localparam logic [4:0] CH_REF_LOW    = 5'h1e;
    localparam logic [4:0] CH_POWER_OFF  = 5'h1f;
    localparam logic [1:0] JUST_TRUNC    = 2'h0;
    localparam logic [1:0] JUST_RIGHT    = 2'h1;
    localparam logic [1:0] JUST_LEFT     = 2'h2;
    localparam logic [1:0] JUST_SIGNED   = 2'h3;

    // ------------------------------------------------------------
    // Timing in conversion clock periods
    // ------------------------------------------------------------
    localparam logic [3:0] CONV_LAST_TICK = 4'hf;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ALIGN = 3'b010,
        ST_CONV  = 3'b100
    } sac_state_e;

endpackage : sac_pkg

// [src/sac_prescaler.sv]
/*
 * Conversion clock prescaler: picks the bus clock or the oscillator tick
 * and divides it by 1, 2, 4, 8 or 16 into one-cycle ticks.
 * Assumes osc_tick is a one-cycle pulse synchronous to mclk.
 */
`timescale 1ns/1ns
module sac_prescaler (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       src_bus,
    input  wire logic [2:0] prescale,
    input  wire logic       osc_tick,
    output logic            adc_tick
);

    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } sac_pre_s;

    sac_pre_s   q;
    sac_pre_s   d;
    logic [3:0] last;
    logic       src_tick;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_comb
    begin
        d        = q;
        src_tick = src_bus | osc_tick;
        last     = prescale[2] ? 4'hf : 4'((5'h01 << prescale[1:0]) - 5'h01);
        d.tick   = 1'b0;
        if (src_tick)
        begin
            if (q.cnt >= last)
            begin
                d.cnt  = 4'h0;
                d.tick = 1'b1;
            end
            else
            begin
                d.cnt = q.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    assign adc_tick = q.tick;

endmodule : sac_prescaler

// [testbench/sac_core_model.sv]
/*
 * Behavioural analog core and oscillator for the converter control block.
 * Assumes mclk at 100 MHz and a design that samples on its last tick.
 */
`timescale 1ns/1ns
module sac_core_model #(
    parameter int OSC_DIV = 4
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [4:0] mux_sel,
    input  wire logic       conv_active,
    input  wire logic       power_off,
    output logic      [9:0] sample_data,
    output logic            osc_tick
);
    int osc_cnt;

    // ------------------------------------------------------------
    // Channel coded sample, reference levels at full and zero scale
    // ------------------------------------------------------------
    function automatic logic [9:0] code(input logic [4:0] c);
        if (c == 5'h1d)
            return 10'h3ff;
        if (c == 5'h1e)
            return 10'h000;
        return {c[2:0], 2'h2, c[2:0], 2'h1};
    endfunction : code

    // Idle core shows a toggling value, the last result and its inverse in turn
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sample_data <= 10'h2aa;
            osc_cnt     <= 0;
            osc_tick    <= 1'b0;
        end
        else
        begin
            sample_data <= (conv_active && !power_off) ? code(mux_sel) : ~sample_data;
            osc_cnt     <= (osc_cnt == OSC_DIV - 1) ? 0 : osc_cnt + 1;
            osc_tick    <= (osc_cnt == OSC_DIV - 1);
        end
    end
endmodule : sac_core_model

// [testbench/sac_control_tb.sv]
/*
 * Self-checking bench of the converter control block.
 * Assumes the core model above and a register port read one cycle later.
 */
`timescale 1ns/1ns
module sac_control_tb;
    typedef struct packed {
        logic [4:0] ch;
        logic [1:0] just;
        logic [9:0] raw;
    } sac_tb_row_s;

    logic       mclk = 1'b0;
    logic       rstn;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rdata;
    logic       osc_tick;
    logic       stop_mode;
    logic [9:0] sample_data;
    logic [4:0] mux_sel;
    logic       conv_active;
    logic       power_off;
    logic       irq;
    int         err_count = 0;
    int         n_tests = 0;
    logic [7:0] d;
    logic [7:0] hi;
    int         n;
    sac_tb_row_s rows [11] = '{
        '{5'h00, 2'h1, 10'h041}, '{5'h01, 2'h1, 10'h0c5}, '{5'h02, 2'h1, 10'h149},
        '{5'h03, 2'h1, 10'h1cd}, '{5'h04, 2'h1, 10'h251}, '{5'h05, 2'h1, 10'h2d5},
        '{5'h06, 2'h1, 10'h359}, '{5'h07, 2'h1, 10'h3dd}, '{5'h1d, 2'h2, 10'h3ff},
        '{5'h1e, 2'h3, 10'h000}, '{5'h02, 2'h0, 10'h149}};
    logic [7:0] rst_addr [9] = '{8'h57, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h60};
    logic [7:0] rst_val  [9] = '{8'h1f, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [2:0] pre_tab  [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0};
    logic       src_tab  [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    int         div_tab  [7] = '{1, 2, 4, 8, 16, 16, 4};

    always #5 mclk = ~mclk;

    sac_control u_dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .osc_tick(osc_tick), .stop_mode(stop_mode),
        .sample_data(sample_data), .mux_sel(mux_sel), .conv_active(conv_active),
        .power_off(power_off), .irq(irq));

    sac_core_model #(.OSC_DIV(4)) u_core (.mclk(mclk), .rstn(rstn), .mux_sel(mux_sel),
        .conv_active(conv_active), .power_off(power_off), .sample_data(sample_data),
        .osc_tick(osc_tick));

    // ------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    task automatic wait_done(output logic [7:0] v);
        v = 8'h00;
        for (int k = 0; k < 60 && v[7] !== 1'b1; k++)
            rd(8'h57, v);
    endtask : wait_done

    task automatic wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 600)
        begin
            @(posedge mclk);
            #1;
            c++;
        end
    endtask : wait_irq

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge mclk);
        $display("Error watchdog expected finish seen hang");
        err_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        stop_mode = 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        chk("irq", 16'h0, irq);
        chk("power_off", 16'h1, power_off);
        wr(8'h59, 8'hff);
        wr(8'h60, 8'hff);
        for (int i = 0; i < 9; i++)
        begin
            rd(rst_addr[i], d);
            chk("reset_reg", rst_val[i], d);
        end
        $display("Test reset finished");

        for (int i = 0; i < 11; i++)
        begin
            wr(8'h58, {3'h0, 1'b1, rows[i].just, 2'h0});
            wr(8'h57, {3'h0, rows[i].ch});
            chk("mux_sel", rows[i].ch, mux_sel);
            wait_done(d);
            chk("done", 16'h1, d[7]);
            chk("irq_off", 16'h0, irq);
            rd(8'h59, hi);
            rd(8'h5a, d);
            case (rows[i].just)
                2'h0: chk("result", {8'h00, rows[i].raw[9:2]}, {hi, d});
                2'h1: chk("result", {6'h00, rows[i].raw}, {hi, d});
                2'h2: chk("result", {rows[i].raw, 6'h00}, {hi, d});
                default: chk("result", {~rows[i].raw[9], rows[i].raw[8:0], 6'h00}, {hi, d});
            endcase
            rd(8'h57, d);
            chk("done_clear", 16'h0, d[7]);
            chk("single", 16'h0, conv_active);
        end
        $display("Test channels finished");

        wr(8'h58, 8'h14);
        wr(8'h57, 8'h42);
        wait_irq(n);
        chk("irq_set", 16'h1, irq);
        rd(8'h57, d);
        chk("status_irq_enable_bit", 16'h42, d);
        repeat (5) @(posedge mclk);
        #1;
        chk("irq_hold", 16'h1, irq);
        rd(8'h59, d);
        chk("irq_rd", 16'h0, irq);
        rd(8'h5a, d);
        wr(8'h57, 8'h42);
        wait_irq(n);
        wr(8'h57, 8'h1f);
        chk("irq_wr", 16'h0, irq);
        chk("power_off", 16'h1, power_off);
        $display("Test interrupt finished");

        wr(8'h58, 8'h10);
        wr(8'h57, 8'h21);
        wait_done(d);
        rd(8'h5a, d);
        wait_done(d);
        chk("cont_done", 16'h1, d[7]);
        chk("cont_run", 16'h1, conv_active);
        wr(8'h57, 8'h01);
        wait_done(d);
        repeat (40) @(posedge mclk);
        #1;
        chk("cont_stop", 16'h0, conv_active);
        $display("Test continuous finished");

        wr(8'h57, 8'h03);
        repeat (3) @(posedge mclk);
        stop_mode <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk("stop_abort", 16'h0, conv_active);
        repeat (40) @(posedge mclk);
        rd(8'h57, d);
        chk("stop_done", 16'h0, d[7]);
        @(posedge mclk);
        stop_mode <= 1'b0;
        wait_done(d);
        chk("resume", 16'h1, d[7]);
        wr(8'h58, 8'h10);
        rd(8'h57, d);
        chk("done_clock", 16'h0, d[7]);
        $display("Test stop finished");

        for (int i = 0; i < 7; i++)
        begin
            wr(8'h58, {pre_tab[i], src_tab[i], 2'h1, 2'h0});
            wr(8'h57, 8'h40);
            wait_irq(n);
            chk("conv_time", 16'h1, (n >= 16 * div_tab[i] && n <= 17 * div_tab[i] + 3));
        end
        wr(8'h57, 8'h1f);
        $display("Test prescaler finished");

        wr(8'h58, 8'h10);
        for (int a = 0; a < 4; a++)
        begin
            wr(8'h5e, {6'h01, a[1:0]});
            rd(8'h5e, d);
            chk("scan_ctrl", {6'h01, a[1:0]}, d);
            wr(8'h57, 8'h40);
            wait_irq(n);
            chk("scan_len", 16'h1, (n >= 16 * (a + 1) && n <= 17 * (a + 1) + 3));
            for (int k = 0; k < 4; k++)
            begin
                rd(8'h5a + k[7:0], d);
                chk("scan_result", (k <= a) ? rows[k].raw[9:2] : 8'h00, d);
            end
        end
        wr(8'h5e, 8'h00);
        $display("Test scan finished");

        wr(8'h57, 8'h61);
        wait_irq(n);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        chk("rst_irq", 16'h0, irq);
        chk("rst_active", 16'h0, conv_active);
        rd(8'h57, d);
        chk("rst_status", 16'h1f, d);
        $display("Test reset in run finished");
        report_and_stop();
    end
endmodule : sac_control_tb
